// File: src/rbwa_top.sv
// Read burst wrap address generator with AXI4-Lite configuration registers
module rbwa_top
  import rbwa_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  // AXI4-Lite read data
  input wire logic s_axi_rready,
  output logic s_axi_rvalid,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Burst sequencing from the serial read engine
  input wire logic burstStart,
  input wire logic [31:0] burstStartAddr,
  input wire logic burstStep,
  input wire logic burstStop,
  // Current burst address
  output logic [31:0] burstAddr,
  output logic burstActive
);

  // ============================================================
  // Configuration registers
  // ============================================================
  logic [7:0] burstCfgPers;
  logic [7:0] burstCfgVol;
  logic [7:0] ifaceCfgPers;
  logic [7:0] ifaceCfgVol;
  logic [7:0] next_burstCfgPers;
  logic [7:0] next_burstCfgVol;
  logic [7:0] next_ifaceCfgPers;
  logic [7:0] next_ifaceCfgVol;

  // ============================================================
  // Write channel state
  // ============================================================
  logic awHeld;
  logic wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic next_awHeld;
  logic next_wHeld;
  logic [7:0] next_awAddr;
  logic [31:0] next_wData;
  logic [3:0] next_wStrb;
  logic next_awReady;
  logic next_wReady;
  logic next_bValid;
  logic [1:0] next_bResp;
  logic doWrite;

  // ============================================================
  // Read channel state
  // ============================================================
  logic next_arReady;
  logic next_rValid;
  logic [31:0] next_rData;
  logic [1:0] next_rResp;

  // ============================================================
  // Burst generator state
  // ============================================================
  rbwa_state_t state;
  rbwa_state_t next_state;
  logic burstWrapOn;
  logic [1:0] burstWrapCode;
  logic next_burstWrapOn;
  logic [1:0] next_burstWrapCode;
  logic [31:0] next_burstAddr;
  logic next_burstActive;

  // Write channel: take address and data in any order, answer after both
  always_comb begin
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awAddr = awAddr;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bValid = s_axi_bvalid;
    next_bResp = s_axi_bresp;
    doWrite = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bValid = 1'b0;
    end
    if (awHeld && wHeld && !s_axi_bvalid) begin
      doWrite = 1'b1;
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bValid = 1'b1;
      next_bResp = RESP_OKAY;
      if (awAddr[7:2] > OFS_IFACE_CFG_VOL[7:2]) begin
        next_bResp = RESP_SLVERR;
      end
    end
    next_awReady = !next_awHeld && !next_bValid;
    next_wReady = !next_wHeld && !next_bValid;
  end

  // Register write decode, byte lane 0 carries each 8-bit register
  always_comb begin
    next_burstCfgPers = burstCfgPers;
    next_burstCfgVol = burstCfgVol;
    next_ifaceCfgPers = ifaceCfgPers;
    next_ifaceCfgVol = ifaceCfgVol;
    if (doWrite && wStrb[0]) begin
      if (awAddr[7:2] == OFS_BURST_CFG_PERS[7:2]) begin
        next_burstCfgPers = wData[7:0];
      end else if (awAddr[7:2] == OFS_BURST_CFG_VOL[7:2]) begin
        next_burstCfgVol = wData[7:0];
      end else if (awAddr[7:2] == OFS_IFACE_CFG_PERS[7:2]) begin
        next_ifaceCfgPers = wData[7:0];
      end else if (awAddr[7:2] == OFS_IFACE_CFG_VOL[7:2]) begin
        next_ifaceCfgVol = wData[7:0];
      end
    end
  end

  // Read channel: one beat, answered the cycle after the address
  always_comb begin
    next_rValid = s_axi_rvalid;
    next_rData = s_axi_rdata;
    next_rResp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rValid = 1'b1;
      next_rResp = RESP_OKAY;
      next_rData = 32'h0000_0000;
      if (s_axi_araddr[7:2] == OFS_BURST_CFG_PERS[7:2]) begin
        next_rData = {24'h00_0000, burstCfgPers};
      end else if (s_axi_araddr[7:2] == OFS_BURST_CFG_VOL[7:2]) begin
        next_rData = {24'h00_0000, burstCfgVol};
      end else if (s_axi_araddr[7:2] == OFS_IFACE_CFG_PERS[7:2]) begin
        next_rData = {24'h00_0000, ifaceCfgPers};
      end else if (s_axi_araddr[7:2] == OFS_IFACE_CFG_VOL[7:2]) begin
        next_rData = {24'h00_0000, ifaceCfgVol};
      end else if (s_axi_araddr[7:2] == OFS_BURST_ADDR[7:2]) begin
        next_rData = burstAddr;
      end else if (s_axi_araddr[7:2] == OFS_BURST_STATUS[7:2]) begin
        next_rData = {29'h0000_0000, burstWrapOn, burstWrapCode};
      end else begin
        next_rResp = RESP_SLVERR;
      end
    end
    next_arReady = !next_rValid;
  end

  // Burst generator: mode frozen at start, volatile copy decides
  always_comb begin
    next_state = state;
    next_burstAddr = burstAddr;
    next_burstWrapOn = burstWrapOn;
    next_burstWrapCode = burstWrapCode;
    case (state)
      RBWA_IDLE: begin
        if (burstStart) begin
          next_state = RBWA_RUN;
          next_burstAddr = burstStartAddr;
          next_burstWrapOn = burstCfgVol[WRAP_EN_BIT];
          next_burstWrapCode = burstCfgVol[WRAP_LEN_LSB +: 2];
        end
      end
      RBWA_RUN: begin
        if (burstStop) begin
          next_state = RBWA_IDLE;
        end else if (burstStart) begin
          next_burstAddr = burstStartAddr;
          next_burstWrapOn = burstCfgVol[WRAP_EN_BIT];
          next_burstWrapCode = burstCfgVol[WRAP_LEN_LSB +: 2];
        end else if (burstStep) begin
          // Advance within the group or straight on
          next_burstAddr = rbwa_next(burstAddr, burstWrapOn,
                                     burstWrapCode);
        end
      end
      default: begin
        next_state = RBWA_IDLE;
      end
    endcase
    next_burstActive = (next_state == RBWA_RUN);
  end

  // Register stage for every group
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      burstCfgPers <= BURST_CFG_RESET;
      burstCfgVol <= BURST_CFG_RESET;
      ifaceCfgPers <= IFACE_CFG_RESET;
      ifaceCfgVol <= IFACE_CFG_RESET;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
      state <= RBWA_IDLE;
      burstAddr <= 32'h0000_0000;
      burstWrapOn <= 1'b0;
      burstWrapCode <= 2'h0;
      burstActive <= 1'b0;
    end else begin
      burstCfgPers <= next_burstCfgPers;
      burstCfgVol <= next_burstCfgVol;
      ifaceCfgPers <= next_ifaceCfgPers;
      ifaceCfgVol <= next_ifaceCfgVol;
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddr <= next_awAddr;
      wData <= next_wData;
      wStrb <= next_wStrb;
      s_axi_awready <= next_awReady;
      s_axi_wready <= next_wReady;
      s_axi_bvalid <= next_bValid;
      s_axi_bresp <= next_bResp;
      s_axi_arready <= next_arReady;
      s_axi_rvalid <= next_rValid;
      s_axi_rdata <= next_rData;
      s_axi_rresp <= next_rResp;
      state <= next_state;
      burstAddr <= next_burstAddr;
      burstWrapOn <= next_burstWrapOn;
      burstWrapCode <= next_burstWrapCode;
      burstActive <= next_burstActive;
    end
  end

endmodule : rbwa_top

// File: shared/rbwa_pkg.sv
// Constants, types and helpers for the read burst wrap addressing block
// ============================================================
// Function
// - Two-bit wrap length code selects group of 8, 16, 32 or 64 bytes.
// - Wrap group is the aligned block of that size holding the start.
// - In 8-byte wrap, after the group's last byte return to its first.
// - Without wrapping, addresses increment and cross every boundary.
// - Wrapped burst may start anywhere; 16-byte from 0C gives 0C..0F, 00.
// - In 64-byte wrap, offset 3F is followed by offset 00 of same group.
// ============================================================
package rbwa_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFS_BURST_CFG_PERS = 8'h00;
  localparam logic [7:0] OFS_BURST_CFG_VOL = 8'h04;
  localparam logic [7:0] OFS_IFACE_CFG_PERS = 8'h08;
  localparam logic [7:0] OFS_IFACE_CFG_VOL = 8'h0C;
  localparam logic [7:0] OFS_BURST_ADDR = 8'h10;
  localparam logic [7:0] OFS_BURST_STATUS = 8'h14;

  // Field positions in the burst configuration registers
  localparam int WRAP_LEN_LSB = 0;
  localparam int WRAP_EN_BIT = 4;

  // Values after reset
  localparam logic [7:0] BURST_CFG_RESET = 8'h00;
  localparam logic [7:0] IFACE_CFG_RESET = 8'h40;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Wrap length codes
  typedef enum logic [1:0] {
    RBWA_WRAP8 = 2'h0,
    RBWA_WRAP16 = 2'h1,
    RBWA_WRAP32 = 2'h2,
    RBWA_WRAP64 = 2'h3
  } rbwa_wrap_t;

  // Burst address generator states, Gray coded
  typedef enum logic [1:0] {
    RBWA_IDLE = 2'h0,
    RBWA_RUN = 2'h1
  } rbwa_state_t;

  // Offset mask of a wrap group
  function automatic logic [31:0] rbwa_mask(input logic [1:0] code);
    logic [31:0] m;
    m = 32'h0000_0007;
    case (code)
      RBWA_WRAP8: m = 32'h0000_0007;
      RBWA_WRAP16: m = 32'h0000_000F;
      RBWA_WRAP32: m = 32'h0000_001F;
      default: m = 32'h0000_003F;
    endcase
    return m;
  endfunction : rbwa_mask

  // Next byte address of a burst
  function automatic logic [31:0] rbwa_next(input logic [31:0] addr,
                                            input logic wrapOn,
                                            input logic [1:0] code);
    logic [31:0] m;
    logic [31:0] inc;
    m = rbwa_mask(code);
    inc = addr + 32'h0000_0001;
    if (wrapOn) begin
      // Keep the aligned base, cycle the offset inside the group
      return (addr & ~m) | (inc & m);
    end
    return inc;
  endfunction : rbwa_next

endpackage : rbwa_pkg

// File: sim/rbwa_checker.sv
// Concurrent checks of the burst wrap address block
module rbwa_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Burst sequencing
  input wire logic burstStart,
  input wire logic [31:0] burstStartAddr,
  input wire logic burstStep,
  input wire logic burstStop,
  input wire logic [31:0] burstAddr,
  input wire logic burstActive
);
  timeunit 1ns;
  timeprecision 1ns;
  // ============================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic adv;
  assign adv = burstActive && burstStep && !burstStop && !burstStart;
  rd_lat_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late");
  rd_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
      $stable(s_axi_rdata)) else $error("Read data dropped");
  wr_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("Write answer dropped");
  start_load_a:
    assert property (burstStart && !burstStop |=> burstActive &&
      burstAddr == $past(burstStartAddr)) else $error("Start not loaded");
  stop_end_a:
    assert property (burstStop |=> !burstActive ##1 !burstActive || burstStart)
    else $error("Stop ignored");
  addr_hold_a:
    assert property (!burstStep && !burstStart |=> $stable(burstAddr))
    else $error("Address moved without step");
  step_low_a:
    assert property (adv |=> burstAddr[2:0] == $past(burstAddr[2:0]) + 3'h1)
    else $error("Step did not advance");
  step_block_a:
    assert property (adv |=> burstAddr[31:6] == $past(burstAddr[31:6]) ||
      burstAddr == $past(burstAddr) + 32'h1) else $error("Step left group");
endmodule : rbwa_checker

bind rbwa_top rbwa_checker i_chk (.sys_clk, .rst, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid,
  .s_axi_bready, .burstStart, .burstStartAddr, .burstStep, .burstStop,
  .burstAddr, .burstActive);

// File: sim/rbwa_host_model.sv
// Host read engine model issuing burst start, steps and stop
module rbwa_host_model (
  // Clock
  input wire logic sys_clk,
  // Burst commands
  output logic burstStart,
  output logic [31:0] burstStartAddr,
  output logic burstStep,
  output logic burstStop
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle levels
  initial begin
    burstStart = 1'h0;
    burstStartAddr = 32'h0;
    burstStep = 1'h0;
    burstStop = 1'h0;
  end
  // One burst of n bytes, prompt or with a gap after each byte
  task automatic run(input logic [31:0] a, input int n, input bit slow);
    int i;
    burstStart <= 1'h1;
    burstStartAddr <= a;
    @(posedge sys_clk);
    burstStart <= 1'h0;
    burstStartAddr <= ~a; // Address no longer valid
    for (i = 0; i < n; i++) begin
      burstStep <= 1'h1;
      @(posedge sys_clk);
      if (slow) begin
        burstStep <= 1'h0;
        @(posedge sys_clk);
      end
    end
    burstStep <= 1'h0;
    burstStop <= 1'h1;
    @(posedge sys_clk);
    burstStop <= 1'h0;
  endtask : run
endmodule : rbwa_host_model

// File: sim/tb_rbwa_top.sv
// Self-checking bench for the burst wrap address block
module tb_rbwa_top;
  import rbwa_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0, rst = 1'h1, expOn = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, vol = 8'h0, mode;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, burstStartAddr, burstAddr;
  logic [31:0] rdVal, expA = 32'h0, lfsr = 32'h6F949076;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic burstStart, burstStep, burstStop, burstActive;
  int error_cnt = 0, compares = 0;
  rbwa_top i_dut (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp,
    .burstStart, .burstStartAddr, .burstStep, .burstStop, .burstAddr,
    .burstActive);
  rbwa_host_model i_host (.sys_clk, .burstStart, .burstStartAddr, .burstStep,
    .burstStop);
  always #5 sys_clk = ~sys_clk;
  // ============================================================
  // Helpers
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  function automatic logic [31:0] nextAddr(logic [31:0] a, logic [7:0] c);
    logic [31:0] m;
    m = (32'h8 << c[WRAP_LEN_LSB +: 2]) - 32'h1;
    if (c[WRAP_EN_BIT]) return (a & ~m) | ((a + 32'h1) & m);
    return a + 32'h1;
  endfunction : nextAddr
  task automatic chkW(logic [31:0] got, logic [31:0] exp, string m);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chkW
  task automatic chkR(logic [1:0] exp);
    chkW({30'h0, resp}, {30'h0, exp}, "response");
  endtask : chkR
  task automatic test_done();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  task automatic axiWr(logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge sys_clk);
    s_axi_awvalid <= 1'h1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'h1;
    s_axi_wdata <= d;
    for (k = 0; k < 20 && !(s_axi_bvalid && s_axi_bready); k++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) s_axi_bready <= 1'h1;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    // Running out of cycles before the response counts as a mismatch
    if (!(s_axi_bvalid && s_axi_bready)) begin
      error_cnt++;
      $display("unexpected %0t write timeout", $time);
      test_done();
    end
    if (a == OFS_BURST_CFG_VOL && resp === RESP_OKAY && s_axi_wstrb[0])
      vol = d[7:0];
  endtask : axiWr
  task automatic axiRd(logic [7:0] a);
    int k;
    @(posedge sys_clk);
    s_axi_arvalid <= 1'h1;
    s_axi_araddr <= a;
    for (k = 0; k < 20 && !(s_axi_rvalid && s_axi_rready); k++) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) s_axi_rready <= 1'h1;
    end
    rdVal = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    // Running out of cycles before the read data counts as a mismatch
    if (!(s_axi_rvalid && s_axi_rready)) begin
      error_cnt++;
      $display("unexpected %0t read timeout", $time);
      test_done();
    end
  endtask : axiRd
  // Expected burst address from the commands seen at the ports
  always @(posedge sys_clk) begin
    if (rst) expOn <= 1'h0;
    else if (burstStop) expOn <= 1'h0;
    else if (burstStart) begin
      expOn <= 1'h1;
      expA <= burstStartAddr;
      mode <= vol;
    end else if (burstStep && expOn) expA <= nextAddr(expA, mode);
  end
  always @(negedge sys_clk) begin
    if (!rst) chkW(burstAddr, expA, "address");
    if (!rst) chkW({31'h0, burstActive}, {31'h0, expOn}, "active");
  end
  // ============================================================
  // Main sequence
  initial begin
    int i;
    logic [31:0] w;
    logic [7:0] c;
    static logic [7:0] cfgT [6] = '{8'h00, 8'h10, 8'h10, 8'h11, 8'h12,
      8'h13};
    static logic [7:0] startT [6] = '{8'h03, 8'h00, 8'h07, 8'h0C, 8'h1E,
      8'h2E};
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    for (i = 0; i < 4; i++) begin
      axiRd(8'(4 * i));
      chkW(rdVal, {24'h0, i < 2 ? BURST_CFG_RESET : IFACE_CFG_RESET}, "rst");
    end
    s_axi_wstrb <= 4'hE;
    axiWr(OFS_BURST_CFG_PERS, 32'hFF);
    s_axi_wstrb <= 4'hF;
    axiRd(OFS_BURST_CFG_PERS);
    chkW(rdVal, 32'h0, "strobe");
    axiWr(OFS_BURST_ADDR, 32'h1);
    chkR(RESP_SLVERR);
    axiRd(8'h18);
    chkR(RESP_SLVERR);
    $display("test reset and refusals done");
    for (i = 0; i < 8; i++) begin
      w = rnd();
      if (i[1]) w[7:6] = 2'h1;
      axiWr(8'(4 * (i % 4)), w);
      chkR(RESP_OKAY);
      axiRd(8'(4 * (i % 4)));
      chkR(RESP_OKAY);
      chkW(rdVal, {24'h0, w[7:0]}, "readback");
    end
    $display("test registers done");
    for (i = 0; i < 16; i++) begin
      w = rnd();
      c = i < 6 ? cfgT[i] : {3'h0, w[4], 2'h0, w[1:0]};
      axiWr(OFS_BURST_CFG_PERS, {24'h0, ~c});
      axiWr(OFS_BURST_CFG_VOL, {24'h0, c});
      i_host.run(i < 6 ? {w[31:8], startT[i]} : w, 70, w[9]);
      // Address and latched mode stay readable after the stop
      axiRd(OFS_BURST_ADDR);
      chkW(rdVal, expA, "burst address");
      axiRd(OFS_BURST_STATUS);
      chkW(rdVal, {29'h0, mode[WRAP_EN_BIT], mode[WRAP_LEN_LSB +: 2]},
        "status");
      chkR(RESP_OKAY);
    end
    $display("test bursts done");
    test_done();
  end
endmodule : tb_rbwa_top
